/* File: otg_status_defs.vh */
// register map, field positions and reset values of the otg status block
`ifndef OTG_STATUS_DEFS_VH
`define OTG_STATUS_DEFS_VH

// ******************************************************************
// register byte offsets
// ******************************************************************
`define OFS_OTG_CTRL      8'h00
`define OFS_INT_EN_RISE   8'h04
`define OFS_INT_EN_FALL   8'h08
`define OFS_USB_STATUS    8'h0C
`define OFS_PENDING       8'h10
`define OFS_CARKIT_EN     8'h14
`define OFS_CARKIT_STATUS 8'h18
`define OFS_RID           8'h1C
`define OFS_IRQ_STATUS    8'h20
`define OFS_IRQ_MASK      8'h24

// ******************************************************************
// field positions
// ******************************************************************
`define BIT_PULL_ENABLE   0
`define BIT_BUS_VALID     1
`define BIT_SESS_VALID    2
`define BIT_SESS_END      3
`define BIT_IDENT_GND     4
`define BIT_IDENT_FLOAT   5
`define BIT_FLOAT_RISE    0
`define BIT_FLOAT_FALL    1
`define BIT_CARKIT_FLOAT  0
`define EVENT_WIDTH       6
`define RID_WIDTH         3
`define RID_LEVELS        5

// ******************************************************************
// reset values
// ******************************************************************
`define RST_OTG_CTRL      8'h00
`define RST_INT_EN        8'h1E
`define RST_CARKIT_EN     8'h00
`define RST_EVENTS        6'h00

// ******************************************************************
// resistance codes
// ******************************************************************
`define RID_GROUND        3'h0
`define RID_75_OHM        3'h1
`define RID_102K          3'h2
`define RID_200K          3'h3
`define RID_440K          3'h4
`define RID_FLOATING      3'h5

`endif

/* File: change_detect.v */
// per-bit change detector with separate rising and falling enables
`timescale 1ns/1ns
`include "otg_status_defs.vh"

module change_detect (
  input wire clk, // system clock
  input wire rst, // synchronous reset, high
  input wire [`EVENT_WIDTH-1:0] level, // current flag levels
  input wire [`EVENT_WIDTH-1:0] rise_en, // report 0 to 1 changes
  input wire [`EVENT_WIDTH-1:0] fall_en, // report 1 to 0 changes
  output wire [`EVENT_WIDTH-1:0] event_pulse // one-cycle change pulses
);

  reg [`EVENT_WIDTH-1:0] prev_reg;
  reg armed_reg;

  // first sample after reset only arms, so no false edge from reset value
  always @(posedge clk) begin
    if (rst) begin
      prev_reg <= `RST_EVENTS;
      armed_reg <= 1'b0;
    end else begin
      prev_reg <= level;
      armed_reg <= 1'b1;
    end
  end

  assign event_pulse = {`EVENT_WIDTH{armed_reg}} &
    ((level & ~prev_reg & rise_en) | (~level & prev_reg & fall_en));

endmodule

/* File: rid_encoder.v */
// converts thermometer trip levels of the resistance converter to a code
`timescale 1ns/1ns
`include "otg_status_defs.vh"

module rid_encoder (
  input wire [`RID_LEVELS-1:0] trip_levels, // thermometer, bit n set above step n
  output reg [`RID_WIDTH-1:0] rid_code // encoded resistance class
);

  function [`RID_WIDTH-1:0] count_ones;
    input [`RID_LEVELS-1:0] t;
    integer i;
    reg [`RID_WIDTH-1:0] n;
    begin
      n = 3'h0;
      for (i = 0; i < `RID_LEVELS; i = i + 1) begin
        n = n + {2'h0, t[i]};
      end
      count_ones = n;
    end
  endfunction

  // a broken thermometer is still counted; ones map to ground..floating
  always @* begin
    case (count_ones(trip_levels))
      3'h0: rid_code = `RID_GROUND; // RULE_04
      3'h1: rid_code = `RID_75_OHM;
      3'h2: rid_code = `RID_102K;
      3'h3: rid_code = `RID_200K;
      3'h4: rid_code = `RID_440K;
      default: rid_code = `RID_FLOATING;
    endcase
  end

endmodule

/* File: otg_id_and_vbus_status.v */
// otg ident pin and bus power status, events, receive commands and wishbone registers
`timescale 1ns/1ns
`include "otg_status_defs.vh"

// How it works
// [RULE_01] link enables pull-up, waits 50 ms, reads ground
// [RULE_02] ground flag 0 for A plug, 1 floating
// [RULE_03] weak pull ground comparator interrupts with pull-up off
// [RULE_04] resistance code 000 ground through 101 floating
// [RULE_05] resistance code readable in synchronous mode
// [RULE_06] float changes send receive command with alternate bit
// [RULE_07] ground/float flags: 11 float, 10 102k, 00 ground
// [RULE_08] pull-up control bit connects internal 100k pull-up
// [RULE_09] ground status bit 4, float carkit bit 0
// [RULE_10] ground flag interrupts per enabled edge direction
// [RULE_11] bus comparator outputs readable in status register
// [RULE_12] session end flag rises below 0.5 volts
// [RULE_13] both enables clear disables session end, reads 0
// [RULE_14] session valid enables only gate its interrupts
// [RULE_15] one shared session valid comparator for both roles
// [RULE_16] both enables clear: bus valid off, reads 0
// [RULE_17] enabled changes stay pending until reported to link
module otg_id_and_vbus_status (
  input wire clk, // system clock, 100 MHz
  input wire rst, // synchronous reset, high
  input wire wb_cyc_i, // wishbone cycle
  input wire wb_stb_i, // wishbone strobe
  input wire wb_we_i, // wishbone write enable
  input wire [7:0] wb_adr_i, // wishbone byte address
  input wire [3:0] wb_sel_i, // wishbone byte selects
  input wire [31:0] wb_dat_i, // wishbone write data
  output reg [31:0] wb_dat_o, // wishbone read data
  output reg wb_ack_o, // wishbone acknowledge
  input wire ident_ground_comp, // ground comparator, low when pin pulled down
  input wire ident_float_comp, // float comparator, high when pin open
  input wire session_end_comp, // bus power below session end level
  input wire session_valid_comp, // shared session valid comparator
  input wire bus_power_valid_comp, // bus power above valid level
  input wire [`RID_LEVELS-1:0] rid_trip_levels, // resistance converter trip levels
  input wire sync_mode, // transceiver is in synchronous mode
  input wire [1:0] line_state, // line state for receive commands
  output reg ident_pin_pull_enable, // connects the 100k ident pull-up
  output reg session_end_comp_en, // powers the session end comparator
  output reg bus_valid_comp_en, // powers the bus valid comparator
  output wire rxcmd_valid, // receive command waiting for the link
  input wire rxcmd_ready, // link takes the receive command
  output reg [7:0] rxcmd_data, // receive command byte
  output reg irq // level interrupt, unmasked status set
);

  // ******************************************************************
  // registers
  // ******************************************************************
  reg [7:0] otg_ctrl_reg;
  reg [7:0] en_rise_reg;
  reg [7:0] en_fall_reg;
  reg [7:0] carkit_en_reg;
  reg [`EVENT_WIDTH-1:0] pending_reg;
  reg [`EVENT_WIDTH-1:0] pending_next;
  reg [`EVENT_WIDTH-1:0] irq_status_reg;
  reg [`EVENT_WIDTH-1:0] irq_status_next;
  reg [`EVENT_WIDTH-1:0] irq_mask_reg;
  reg [`RID_WIDTH-1:0] rid_reg;
  reg [`EVENT_WIDTH-1:0] flags_reg;

  wire [`RID_WIDTH-1:0] rid_code;
  wire [`EVENT_WIDTH-1:0] flags;
  wire [`EVENT_WIDTH-1:0] rise_en;
  wire [`EVENT_WIDTH-1:0] fall_en;
  wire [`EVENT_WIDTH-1:0] events;
  wire sess_end_on;
  wire bus_valid_on;
  wire float_on;
  wire bus_req;
  wire wr_lo;
  wire rxcmd_take;
  wire [`EVENT_WIDTH-1:0] wr_clear;
  wire wr_ctrl;
  wire wr_rise;
  wire wr_fall;
  wire wr_carkit;
  wire wr_mask;
  wire wr_clr;

  // ******************************************************************
  // helpers
  // ******************************************************************
  // a comparator stays powered while either edge enable is set
  function comp_enabled;
    input [7:0] rise;
    input [7:0] fall;
    input integer pos;
    begin
      comp_enabled = rise[pos] | fall[pos];
    end
  endfunction

  // registers sit in the low byte; upper bytes read 0
  function [31:0] low_byte;
    input [7:0] v;
    begin
      low_byte = {24'h000000, v};
    end
  endfunction

  // six-bit event words
  function [31:0] event_word;
    input [`EVENT_WIDTH-1:0] v;
    begin
      event_word = low_byte({2'h0, v});
    end
  endfunction

  // ******************************************************************
  // comparator enables and flags
  // ******************************************************************
  // the session end or bus valid comparator is off when its rising and falling enables are both clear
  assign sess_end_on = comp_enabled(en_rise_reg, en_fall_reg, `BIT_SESS_END); // RULE_13
  assign bus_valid_on = comp_enabled(en_rise_reg, en_fall_reg, `BIT_BUS_VALID); // RULE_16
  // the float comparator only means something with the strong pull-up on
  assign float_on = otg_ctrl_reg[`BIT_PULL_ENABLE]; // RULE_07

  assign flags[0] = 1'b0;
  assign flags[`BIT_BUS_VALID] = bus_power_valid_comp & bus_valid_on; // RULE_11 RULE_16
  // session valid is never powered down; only its interrupts are gated
  assign flags[`BIT_SESS_VALID] = session_valid_comp; // RULE_14 RULE_15
  assign flags[`BIT_SESS_END] = session_end_comp & sess_end_on; // RULE_12 RULE_13
  // ground comparator works from the weak pull as well as the strong one
  assign flags[`BIT_IDENT_GND] = ident_ground_comp; // RULE_02 RULE_03
  assign flags[`BIT_IDENT_FLOAT] = ident_float_comp & float_on; // RULE_07

  assign rise_en = {carkit_en_reg[`BIT_FLOAT_RISE], en_rise_reg[4:1], 1'b0}; // RULE_06
  assign fall_en = {carkit_en_reg[`BIT_FLOAT_FALL], en_fall_reg[4:1], 1'b0}; // RULE_06

  always @* begin
    ident_pin_pull_enable = otg_ctrl_reg[`BIT_PULL_ENABLE]; // RULE_08
    session_end_comp_en = sess_end_on; // RULE_13
    bus_valid_comp_en = bus_valid_on; // RULE_16
  end

  // ******************************************************************
  // change detection and resistance converter
  // ******************************************************************
  change_detect u_change (
    .clk(clk),
    .rst(rst),
    .level(flags),
    .rise_en(rise_en),
    .fall_en(fall_en),
    .event_pulse(events) // RULE_10 RULE_03
  );

  rid_encoder u_rid (
    .trip_levels(rid_trip_levels),
    .rid_code(rid_code) // RULE_04
  );

  // code only tracks the converter in synchronous mode, held otherwise
  always @(posedge clk) begin
    if (rst) begin
      rid_reg <= `RID_FLOATING;
    end else if (sync_mode) begin
      rid_reg <= rid_code; // RULE_05
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      flags_reg <= `RST_EVENTS;
    end else begin
      flags_reg <= flags;
    end
  end

  // ******************************************************************
  // wishbone slave
  // ******************************************************************
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_lo = bus_req & wb_we_i & wb_sel_i[0];
  // one strobe per writable register; other offsets write nothing
  assign wr_ctrl = wr_lo & (wb_adr_i == `OFS_OTG_CTRL);
  assign wr_rise = wr_lo & (wb_adr_i == `OFS_INT_EN_RISE);
  assign wr_fall = wr_lo & (wb_adr_i == `OFS_INT_EN_FALL);
  assign wr_carkit = wr_lo & (wb_adr_i == `OFS_CARKIT_EN);
  assign wr_mask = wr_lo & (wb_adr_i == `OFS_IRQ_MASK);
  assign wr_clr = wr_lo & (wb_adr_i == `OFS_IRQ_STATUS);

  always @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // ******************************************************************
  // register writes
  // ******************************************************************
  // one process per register keeps each reset value next to its write
  always @(posedge clk) begin
    if (rst) begin
      otg_ctrl_reg <= `RST_OTG_CTRL;
    end else if (wr_ctrl) begin
      otg_ctrl_reg <= wb_dat_i[7:0]; // RULE_08
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      en_rise_reg <= `RST_INT_EN;
    end else if (wr_rise) begin
      en_rise_reg <= wb_dat_i[7:0]; // RULE_10
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      en_fall_reg <= `RST_INT_EN;
    end else if (wr_fall) begin
      en_fall_reg <= wb_dat_i[7:0]; // RULE_10
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      carkit_en_reg <= `RST_CARKIT_EN;
    end else if (wr_carkit) begin
      carkit_en_reg <= wb_dat_i[7:0]; // RULE_06
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      irq_mask_reg <= `RST_EVENTS;
    end else if (wr_mask) begin
      irq_mask_reg <= wb_dat_i[`EVENT_WIDTH-1:0];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_req & ~wb_we_i) begin
      case (wb_adr_i)
        `OFS_OTG_CTRL: wb_dat_o <= low_byte(otg_ctrl_reg);
        `OFS_INT_EN_RISE: wb_dat_o <= low_byte(en_rise_reg);
        `OFS_INT_EN_FALL: wb_dat_o <= low_byte(en_fall_reg);
        `OFS_USB_STATUS: wb_dat_o <= low_byte({3'h0, flags_reg[4:0]}); // RULE_09 RULE_11
        `OFS_PENDING: wb_dat_o <= event_word(pending_reg);
        `OFS_CARKIT_EN: wb_dat_o <= low_byte(carkit_en_reg);
        `OFS_CARKIT_STATUS: wb_dat_o <= low_byte({7'h00, flags_reg[`BIT_IDENT_FLOAT]}); // RULE_09
        `OFS_RID: wb_dat_o <= low_byte({5'h00, rid_reg}); // RULE_05
        `OFS_IRQ_STATUS: wb_dat_o <= event_word(irq_status_reg);
        `OFS_IRQ_MASK: wb_dat_o <= event_word(irq_mask_reg);
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // ******************************************************************
  // sticky interrupt status
  // ******************************************************************
  assign wr_clear = wr_clr ? wb_dat_i[`EVENT_WIDTH-1:0] : `RST_EVENTS;

  // a new event in the clearing cycle survives: set applied after clear
  always @* begin
    irq_status_next = (irq_status_reg & ~wr_clear) | events; // RULE_10 RULE_03
  end

  always @(posedge clk) begin
    if (rst) begin
      irq_status_reg <= `RST_EVENTS;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  // ******************************************************************
  // interrupt output
  // ******************************************************************
  // taken from the next status so the line moves with the status bit
  always @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_next & irq_mask_reg);
    end
  end

  // ******************************************************************
  // pending events and receive commands to the link
  // ******************************************************************
  assign rxcmd_valid = |pending_reg; // RULE_17
  assign rxcmd_take = rxcmd_valid & rxcmd_ready;

  // reported events clear; events arriving meanwhile stay pending
  always @* begin
    pending_next = pending_reg;
    if (rxcmd_take) begin
      pending_next = `RST_EVENTS;
    end
    pending_next = pending_next | events; // RULE_17
  end

  always @(posedge clk) begin
    if (rst) begin
      pending_reg <= `RST_EVENTS;
    end else begin
      pending_reg <= pending_next;
    end
  end

  // ******************************************************************
  // receive command byte
  // ******************************************************************
  // status packed for the link; events merge while it waits
  function [1:0] bus_power_state;
    input [`EVENT_WIDTH-1:0] f;
    begin
      if (f[`BIT_BUS_VALID]) begin
        bus_power_state = 2'h3;
      end else if (f[`BIT_SESS_VALID]) begin
        bus_power_state = 2'h2;
      end else if (!f[`BIT_SESS_END]) begin
        bus_power_state = 2'h1;
      end else begin
        bus_power_state = 2'h0;
      end
    end
  endfunction

  // byte: alt bit, ident ground, rx event 0, bus power state, line state
  always @(posedge clk) begin
    if (rst) begin
      rxcmd_data <= 8'h00;
    end else begin
      rxcmd_data <= {pending_next[`BIT_IDENT_FLOAT], flags[`BIT_IDENT_GND], 2'h0,
                     bus_power_state(flags), line_state}; // RULE_06
    end
  end

endmodule

/* File: otg_status_chk.sv */
// concurrent checks on the otg ident and bus power status block ports
`timescale 1ns/1ns
`include "otg_status_defs.vh"

module otg_status_chk (
  input wire clk, // clock
  input wire rst, // sync reset
  input wire wb_we_i, // write enable
  input wire [7:0] wb_adr_i, // address
  input wire [3:0] wb_sel_i, // byte selects
  input wire [31:0] wb_dat_i, // write data
  input wire [31:0] wb_dat_o, // read data
  input wire wb_ack_o, // acknowledge
  input wire ident_ground_comp, // ground comparator
  input wire ident_float_comp, // float comparator
  input wire session_end_comp, // session end comparator
  input wire session_valid_comp, // session valid comparator
  input wire bus_power_valid_comp, // bus valid comparator
  input wire ident_pin_pull_enable, // pull-up control
  input wire session_end_comp_en, // session end power
  input wire bus_valid_comp_en, // bus valid power
  input wire rxcmd_valid, // command waiting
  input wire rxcmd_ready // link taking
);
  // ******************************************************************
  // settle tracking
  // ******************************************************************
  // reads only judged once inputs sat still, as status is registered twice
  wire [7:0] watch = {ident_ground_comp, ident_float_comp, session_end_comp,
    session_valid_comp, bus_power_valid_comp, ident_pin_pull_enable,
    session_end_comp_en, bus_valid_comp_en};
  reg [7:0] watch_reg;
  reg [2:0] quiet_reg;
  always @(posedge clk) begin
    watch_reg <= watch;
    if (rst || watch != watch_reg)
      quiet_reg <= 3'h0;
    else if (quiet_reg != 3'h7)
      quiet_reg <= quiet_reg + 3'h1;
  end
  wire rd_ok = wb_ack_o && !wb_we_i && quiet_reg > 3'h3;

  // ******************************************************************
  // properties
  // ******************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ground_change;
    $changed(ident_ground_comp);
  endsequence
  sequence s_cmd_soon;
    ##[1:4] rxcmd_valid;
  endsequence

  a_pull_write: assert property (
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `OFS_OTG_CTRL
    |-> ident_pin_pull_enable == wb_dat_i[0]) else $error("pull enable off its write");
  a_ground_read: assert property (
    rd_ok && wb_adr_i == `OFS_USB_STATUS |-> wb_dat_o[4] == ident_ground_comp)
    else $error("ground flag read wrong");
  a_sess_valid_read: assert property (
    rd_ok && wb_adr_i == `OFS_USB_STATUS |-> wb_dat_o[2] == session_valid_comp)
    else $error("session valid read wrong");
  a_sess_end_read: assert property (
    rd_ok && wb_adr_i == `OFS_USB_STATUS
    |-> wb_dat_o[3] == (session_end_comp & session_end_comp_en)) else $error("session end read wrong");
  a_bus_valid_read: assert property (
    rd_ok && wb_adr_i == `OFS_USB_STATUS
    |-> wb_dat_o[1] == (bus_power_valid_comp & bus_valid_comp_en)) else $error("bus valid read wrong");
  a_float_read: assert property (
    rd_ok && wb_adr_i == `OFS_CARKIT_STATUS
    |-> wb_dat_o[0] == (ident_float_comp & ident_pin_pull_enable)) else $error("float read wrong");
  a_ground_cmd: assert property (
    s_ground_change |-> s_cmd_soon) else $error("ground change not reported");
  a_cmd_pending: assert property (
    rxcmd_valid && !rxcmd_ready |=> rxcmd_valid) else $error("command lost before taken");
endmodule

bind otg_id_and_vbus_status otg_status_chk u_chk (.clk(clk), .rst(rst), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .ident_ground_comp(ident_ground_comp), .ident_float_comp(ident_float_comp),
  .session_end_comp(session_end_comp), .session_valid_comp(session_valid_comp),
  .bus_power_valid_comp(bus_power_valid_comp), .ident_pin_pull_enable(ident_pin_pull_enable),
  .session_end_comp_en(session_end_comp_en), .bus_valid_comp_en(bus_valid_comp_en),
  .rxcmd_valid(rxcmd_valid), .rxcmd_ready(rxcmd_ready));

/* File: link_model.sv */
// link controller model that takes receive commands
`timescale 1ns/1ns

module link_model (
  input wire clk, // clock
  input wire rst, // sync reset
  input wire stall, // hold off taking
  input wire rxcmd_valid, // command waiting
  input wire [7:0] rxcmd_data, // command byte
  output reg rxcmd_ready, // taking commands
  output reg [7:0] last_cmd, // last byte taken
  output reg [7:0] cmd_count // commands taken
);
  always @(posedge clk) begin
    if (rst) begin
      rxcmd_ready <= 1'b0;
      last_cmd <= 8'h00;
      cmd_count <= 8'h00;
    end else begin
      rxcmd_ready <= !stall;
      if (rxcmd_valid && rxcmd_ready) begin
        last_cmd <= rxcmd_data;
        cmd_count <= cmd_count + 8'h01;
      end
    end
  end
endmodule

/* File: tb.sv */
// self-checking bench for the otg ident and bus power status block
`timescale 1ns/1ns
`include "otg_status_defs.vh"

module tb;
  localparam SETTLE = 20; // stands in for the long pull-up settle wait
  localparam ALL = 32'hFFFFFFFF;
  reg clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [3:0] wb_sel_i = 4'hF;
  reg [31:0] wb_dat_i = 32'h0, q;
  reg ident_ground_comp = 1'b1, ident_float_comp = 1'b1, session_end_comp = 1'b1;
  reg session_valid_comp = 1'b0, bus_power_valid_comp = 1'b0, sync_mode = 1'b0, stall = 1'b0;
  reg [4:0] rid_trip_levels = 5'h00;
  reg [1:0] line_state = 2'h2;
  reg [7:0] cnt;
  wire [31:0] wb_dat_o;
  wire [7:0] rxcmd_data, last_cmd, cmd_count;
  wire wb_ack_o, ident_pin_pull_enable, session_end_comp_en, bus_valid_comp_en;
  wire rxcmd_valid, rxcmd_ready, irq;
  integer bad_count = 0, samples_checked = 0, cycles = 0;

  otg_id_and_vbus_status DUT (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ident_ground_comp(ident_ground_comp),
    .ident_float_comp(ident_float_comp), .session_end_comp(session_end_comp),
    .session_valid_comp(session_valid_comp), .bus_power_valid_comp(bus_power_valid_comp),
    .rid_trip_levels(rid_trip_levels), .sync_mode(sync_mode), .line_state(line_state),
    .ident_pin_pull_enable(ident_pin_pull_enable), .session_end_comp_en(session_end_comp_en),
    .bus_valid_comp_en(bus_valid_comp_en), .rxcmd_valid(rxcmd_valid),
    .rxcmd_ready(rxcmd_ready), .rxcmd_data(rxcmd_data), .irq(irq));
  link_model link (.clk(clk), .rst(rst), .stall(stall), .rxcmd_valid(rxcmd_valid),
    .rxcmd_data(rxcmd_data), .rxcmd_ready(rxcmd_ready), .last_cmd(last_cmd), .cmd_count(cmd_count));

  // ******************************************************************
  // shared tasks
  // ******************************************************************
  task check(input [8*12-1:0] name, input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // one classic cycle; the ack edge is the only point where data is taken
  task wb(input [7:0] a, input we, input [31:0] d);
    begin
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_sel_i <= 4'hF;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk);
      while (wb_ack_o !== 1'b1) @(posedge clk);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rdm(input [8*12-1:0] name, input [7:0] a, input [31:0] m, input [31:0] e);
    begin
      wb(a, 1'b0, 32'h0);
      check(name, q & m, e);
    end
  endtask
  task w6;
    repeat (6) @(posedge clk);
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask

  // ******************************************************************
  // scenarios
  // ******************************************************************
  task t_reset;
    begin
      rdm("otg_ctrl", `OFS_OTG_CTRL, ALL, 32'h0);
      rdm("en_rise", `OFS_INT_EN_RISE, ALL, 32'h1E);
      rdm("en_fall", `OFS_INT_EN_FALL, ALL, 32'h1E);
      rdm("rid", `OFS_RID, ALL, 32'h5);
      rdm("unmapped", 8'h30, ALL, 32'h0);
    end
  endtask
  task t_ident;
    integer k;
    reg [1:0] v;
    begin
      wb(`OFS_OTG_CTRL, 1'b1, 32'h1);
      check("pull_en", {31'h0, ident_pin_pull_enable}, 32'h1);
      repeat (SETTLE) @(posedge clk);
      for (k = 0; k < 3; k = k + 1) begin
        v = (k == 0) ? 2'h3 : (k == 1) ? 2'h2 : 2'h0;
        ident_ground_comp <= v[1];
        ident_float_comp <= v[0];
        w6;
        rdm("ground", `OFS_USB_STATUS, 32'h10, {27'h0, v[1], 4'h0});
        rdm("float", `OFS_CARKIT_STATUS, 32'h1, {31'h0, v[0]});
      end
      ident_ground_comp <= 1'b1;
      ident_float_comp <= 1'b1;
      w6;
    end
  endtask
  task t_float;
    begin
      wb(`OFS_CARKIT_EN, 1'b1, 32'h3);
      stall <= 1'b1;
      line_state <= 2'h1;
      ident_float_comp <= 1'b0;
      session_end_comp <= 1'b0;
      session_valid_comp <= 1'b1;
      w6;
      check("rxcmd_valid", {31'h0, rxcmd_valid}, 32'h1);
      rdm("pending", `OFS_PENDING, ALL, 32'h2C);
      stall <= 1'b0;
      w6;
      check("rxcmd", {24'h0, last_cmd}, 32'hC9);
    end
  endtask
  task t_rid;
    integer n;
    begin
      sync_mode <= 1'b1;
      for (n = 0; n < 6; n = n + 1) begin
        rid_trip_levels <= (5'h1 << n) - 5'h1;
        w6;
        rdm("rid", `OFS_RID, 32'h7, n);
      end
      sync_mode <= 1'b0;
      rid_trip_levels <= 5'h03;
      w6;
      rdm("rid_hold", `OFS_RID, 32'h7, 32'h5);
    end
  endtask
  task t_vbus;
    begin
      bus_power_valid_comp <= 1'b1;
      session_end_comp <= 1'b1;
      session_valid_comp <= 1'b0;
      w6;
      rdm("vbus", `OFS_USB_STATUS, 32'hE, 32'hA);
      wb(`OFS_INT_EN_RISE, 1'b1, 32'h10);
      wb(`OFS_INT_EN_FALL, 1'b1, 32'h10);
      check("comp_en", {30'h0, session_end_comp_en, bus_valid_comp_en}, 32'h0);
      w6;
      cnt = cmd_count;
      session_valid_comp <= 1'b1;
      w6;
      rdm("vbus_off", `OFS_USB_STATUS, 32'hE, 32'h4);
      check("cmd_count", {24'h0, cmd_count}, {24'h0, cnt});
      wb(`OFS_INT_EN_RISE, 1'b1, 32'h1E);
      wb(`OFS_INT_EN_FALL, 1'b1, 32'h1E);
    end
  endtask
  task t_irq;
    begin
      wb(`OFS_OTG_CTRL, 1'b1, 32'h0);
      wb(`OFS_IRQ_MASK, 1'b1, 32'h10);
      rdm("irq_mask", `OFS_IRQ_MASK, ALL, 32'h10);
      wb(`OFS_IRQ_STATUS, 1'b1, 32'h3F);
      check("irq_idle", {31'h0, irq}, 32'h0);
      ident_ground_comp <= 1'b0;
      w6;
      check("irq_set", {31'h0, irq}, 32'h1);
      rdm("irq_status", `OFS_IRQ_STATUS, 32'h10, 32'h10);
      wb(`OFS_IRQ_STATUS, 1'b1, 32'h10);
      check("irq_clear", {31'h0, irq}, 32'h0);
      wb(`OFS_IRQ_MASK, 1'b1, 32'h0);
      ident_ground_comp <= 1'b1;
      w6;
      check("irq_masked", {31'h0, irq}, 32'h0);
      rdm("irq_rise", `OFS_IRQ_STATUS, 32'h10, 32'h10);
    end
  endtask

  // ******************************************************************
  // run control
  // ******************************************************************
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count = bad_count + 1;
      finish_test;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_ident;
    t_float;
    t_rid;
    t_vbus;
    t_irq;
    finish_test;
  end
endmodule
